// File: src/dss_sequencer.sv
// dual slot sampling sequencer: registers, triggers, slot timing, routing
//
// Overview of operation
// - every period runs slot A, then slot B, skipping a slot whose routing code is 0; each stimulus through capture.
// - each slot has separate delay, spacing, count, routing and LED output.
// - slot A active time is delay plus count times spacing plus 68 us compute; count is 0x31 top byte.
// - slot B active time is delay plus count times spacing plus 20 us compute; count is 0x36 top byte.
// - compute time of 68 us after slot A, 20 us after slot B; skipped slots none.
// - slot A LED delay is 0x30 low byte, 23 to 63 us.
// - slot B LED delay is 0x35 low byte, 23 to 63 us.
// - slot A pulse spacing is 0x31 low byte, 19 to 63 us.
// - slot B pulse spacing is 0x36 low byte, 19 to 63 us.
// - at least 222 us sleep separates consecutive sampling periods.
// - routing field per slot: bits 11:8 slot B, bits 7:4 slot A.
// - routing codes 0 to 3 map inputs onto channels as tabled.
// - routing codes 4 to 7 map inputs onto channels as tabled.
// - 16-bit rate register sets the period; 6-bit trim tunes the 32 kHz clock.
// - the 32 kHz clock times the periods; a 1 us tick advances the state machine.
// - 2-bit field enables external sync and picks the trigger pin.
// - selected rising edge starts a period after one to two 32 kHz cycles.
// - an external 32 kHz reference on general pin one may replace the clock.
// - mode field: 0 standby, 1 program, 2 normal; starts in standby.
module dss_sequencer (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  output logic [15:0] reg_rdata,
  input wire logic general_pin_zero,
  input wire logic general_pin_one,
  output logic emitter_output_first,
  output logic emitter_output_second,
  output logic capture_strobe,
  output logic sample_start,
  output logic slot_a_active,
  output logic slot_b_active,
  output logic [7:0] route_channel_1,
  output logic [7:0] route_channel_2,
  output logic [7:0] route_channel_3,
  output logic [7:0] route_channel_4,
  output logic seq_busy
);
  import dss_pkg::*;

  typedef struct packed {
    logic [15:0] mode_reg;
    logic [15:0] rate_reg;
    logic [15:0] route_reg;
    logic [15:0] dly_a_reg;
    logic [15:0] cnt_a_reg;
    logic [15:0] dly_b_reg;
    logic [15:0] cnt_b_reg;
    logic [15:0] xcfg_reg;
    logic [15:0] clk_reg;
    logic [15:0] pin_reg;
    logic [15:0] rdata;
    logic [15:0] rate_cnt;
    logic pend;
    logic armed;
    dss_state_t state;
    logic slot_b;
    logic [7:0] us_cnt;
    logic [7:0] pulses_left;
    logic [7:0] chk_us;
    logic [7:0] chk_led;
    logic led_a;
    logic led_b;
    logic capture;
    logic start;
    logic [31:0] route;
    logic busy;
    logic act_a;
    logic act_b;
  } dss_seq_t;

  dss_seq_t r;
  dss_seq_t n;

  logic [1:0] pin_rise;
  logic us_tick;
  logic smp_tick;
  logic [1:0] mode;
  logic [1:0] sync_sel;
  logic [3:0] code_a;
  logic [3:0] code_b;
  logic [7:0] cur_dly;
  logic [7:0] cur_spc;
  logic [7:0] cur_cnt;
  logic [7:0] comp_us;
  logic sync_edge;
  logic fire;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] dss_clamp(input logic [7:0] v, input logic [7:0] lo);
    if (v < lo)
      return lo;
    else if (v > TIME_MAX_US)
      return TIME_MAX_US;
    else
      return v;
  endfunction

  // channel 4..1 masks, bit k of a mask is photodiode input k+1
  function automatic logic [31:0] dss_route(input logic [3:0] code);
    case (code)
      4'h1: return 32'h0000_030C;
      4'h2: return 32'h0000_30C0;
      4'h3: return 32'h0000_000F;
      4'h4: return 32'h8040_2010;
      4'h5: return 32'h0804_0201;
      4'h6: return 32'h0000_300C;
      4'h7: return 32'h0000_00F0;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // pins and timebase
  // -----------------------------------------------------------------
  dss_pin_sync u_pins (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in({general_pin_one, general_pin_zero}),
    .pin_level(),
    .pin_rise(pin_rise)
  );

  dss_tick_gen u_ticks (
    .clk(clk),
    .sys_rst(sys_rst),
    .trim(r.clk_reg[TRIM_LSB +: 6]),
    .ext_sel(r.clk_reg[CLKSRC_LSB +: 2] == CLKSRC_EXT),
    .ext_rise(pin_rise[1]),
    .us_tick(us_tick),
    .smp_tick(smp_tick)
  );

  // -----------------------------------------------------------------
  // mode, sync and per-slot settings
  // -----------------------------------------------------------------
  assign mode = r.mode_reg[MODE_LSB +: 2];
  assign sync_sel = r.pin_reg[SYNC_LSB +: 2];
  assign code_a = r.route_reg[ROUTE_A_LSB +: 4];
  assign code_b = r.route_reg[ROUTE_B_LSB +: 4];
  assign cur_dly = r.slot_b ? dss_clamp(r.dly_b_reg[LOW_LSB +: 8], DLY_MIN_US)
                            : dss_clamp(r.dly_a_reg[LOW_LSB +: 8], DLY_MIN_US);
  assign cur_spc = r.slot_b ? dss_clamp(r.cnt_b_reg[LOW_LSB +: 8], SPC_MIN_US)
                            : dss_clamp(r.cnt_a_reg[LOW_LSB +: 8], SPC_MIN_US);
  assign cur_cnt = r.slot_b ? r.cnt_b_reg[COUNT_LSB +: 8] : r.cnt_a_reg[COUNT_LSB +: 8];
  assign comp_us = r.slot_b ? T_COMPUTE_B_US : T_COMPUTE_A_US;
  assign sync_edge = (sync_sel == SYNC_PIN0) ? pin_rise[0] :
                     (sync_sel == SYNC_PIN1) ? pin_rise[1] : 1'b0;

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb
  begin
    n = r;
    fire = 1'b0;
    n.led_a = 1'b0;
    n.led_b = 1'b0;
    n.capture = 1'b0;
    n.start = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        OFF_MODE: n.mode_reg = reg_wdata;
        OFF_RATE: n.rate_reg = reg_wdata;
        OFF_ROUTE: n.route_reg = reg_wdata;
        OFF_DLY_A: n.dly_a_reg = reg_wdata;
        OFF_CNT_A: n.cnt_a_reg = reg_wdata;
        OFF_DLY_B: n.dly_b_reg = reg_wdata;
        OFF_CNT_B: n.cnt_b_reg = reg_wdata;
        OFF_XCFG: n.xcfg_reg = reg_wdata;
        OFF_CLK: n.clk_reg = reg_wdata;
        OFF_PIN: n.pin_reg = reg_wdata;
        default: ;
      endcase
    end
    case (reg_addr)
      OFF_MODE: n.rdata = r.mode_reg;
      OFF_RATE: n.rdata = r.rate_reg;
      OFF_ROUTE: n.rdata = r.route_reg;
      OFF_DLY_A: n.rdata = r.dly_a_reg;
      OFF_CNT_A: n.rdata = r.cnt_a_reg;
      OFF_DLY_B: n.rdata = r.dly_b_reg;
      OFF_CNT_B: n.rdata = r.cnt_b_reg;
      OFF_XCFG: n.rdata = r.xcfg_reg;
      OFF_CLK: n.rdata = r.clk_reg;
      OFF_PIN: n.rdata = r.pin_reg;
      default: n.rdata = 16'h0000;
    endcase
    if (sync_sel == SYNC_OFF)
    begin
      n.pend = 1'b0;
      n.armed = 1'b0;
      if (smp_tick)
      begin
        if (r.rate_cnt + 16'h0001 >= r.rate_reg)
        begin
          fire = 1'b1;
          n.rate_cnt = 16'h0000;
        end
        else
          n.rate_cnt = r.rate_cnt + 16'h0001;
      end
    end
    else
    begin
      // edge waits for one to two sample clocks
      n.rate_cnt = 16'h0000;
      if (smp_tick)
      begin
        if (r.armed)
        begin
          fire = 1'b1;
          n.armed = 1'b0;
        end
        else if (r.pend)
        begin
          n.armed = 1'b1;
          n.pend = 1'b0;
        end
      end
      if (sync_edge)
        n.pend = 1'b1;
    end
    case (r.state)
      ST_IDLE:
      begin
        if (fire && mode == MODE_NORMAL)
        begin
          n.start = 1'b1;
          n.us_cnt = 8'h00;
          if (code_a != 4'h0)
          begin
            n.state = ST_DELAY;
            n.slot_b = 1'b0;
          end
          else if (code_b != 4'h0)
          begin
            n.state = ST_DELAY;
            n.slot_b = 1'b1;
          end
          else
            n.state = ST_SLEEP;
        end
      end
      ST_DELAY:
      begin
        if (us_tick)
        begin
          if (r.us_cnt + 8'h01 == cur_dly)
          begin
            n.us_cnt = 8'h00;
            n.pulses_left = cur_cnt;
            n.state = (cur_cnt == 8'h00) ? ST_COMPUTE : ST_PULSE;
          end
          else
            n.us_cnt = r.us_cnt + 8'h01;
        end
      end
      ST_PULSE:
      begin
        if (us_tick)
        begin
          if (r.us_cnt + 8'h01 == cur_spc)
          begin
            n.capture = 1'b1;
            n.us_cnt = 8'h00;
            n.pulses_left = r.pulses_left - 8'h01;
            if (r.pulses_left == 8'h01)
              n.state = ST_COMPUTE;
          end
          else
            n.us_cnt = r.us_cnt + 8'h01;
        end
      end
      ST_COMPUTE:
      begin
        if (us_tick)
        begin
          if (r.us_cnt + 8'h01 == comp_us)
          begin
            n.us_cnt = 8'h00;
            if (!r.slot_b && code_b != 4'h0)
            begin
              n.state = ST_DELAY;
              n.slot_b = 1'b1;
            end
            else
              n.state = ST_SLEEP;
          end
          else
            n.us_cnt = r.us_cnt + 8'h01;
        end
      end
      ST_SLEEP:
      begin
        if (us_tick)
        begin
          if (r.us_cnt + 8'h01 == T_SLEEP_US)
          begin
            n.us_cnt = 8'h00;
            n.slot_b = 1'b0;
            n.state = ST_IDLE;
          end
          else
            n.us_cnt = r.us_cnt + 8'h01;
        end
      end
      default: n.state = ST_IDLE;
    endcase
    if (mode != MODE_NORMAL)
    begin
      n.state = ST_IDLE;
      n.slot_b = 1'b0;
      n.us_cnt = 8'h00;
      n.pend = 1'b0;
      n.armed = 1'b0;
    end
    if (n.state != r.state)
      n.chk_us = 8'h00;
    else if (us_tick)
      n.chk_us = r.chk_us + 8'h01;
    if (r.state != ST_PULSE)
      n.chk_led = 8'h00;
    else if (n.capture)
      n.chk_led = r.chk_led + 8'h01;
    // LED of the running slot only
    n.led_a = n.state == ST_PULSE && n.us_cnt == 8'h00 && !n.slot_b;
    n.led_b = n.state == ST_PULSE && n.us_cnt == 8'h00 && n.slot_b;
    if (n.state == ST_DELAY || n.state == ST_PULSE)
      n.route = dss_route(n.slot_b ? code_b : code_a);
    else
      n.route = 32'h0000_0000;
    n.busy = n.state != ST_IDLE;
    n.act_a = n.busy && !n.slot_b && n.state != ST_SLEEP;
    n.act_b = n.busy && n.slot_b && n.state != ST_SLEEP;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.mode_reg <= REG_RESET;
      r.state <= ST_IDLE;
    end
    else
      r <= n;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign reg_rdata = r.rdata;
  assign emitter_output_first = r.led_a;
  assign emitter_output_second = r.led_b;
  assign capture_strobe = r.capture;
  assign sample_start = r.start;
  assign slot_a_active = r.act_a;
  assign slot_b_active = r.act_b;
  assign route_channel_1 = r.route[7:0];
  assign route_channel_2 = r.route[15:8];
  assign route_channel_3 = r.route[23:16];
  assign route_channel_4 = r.route[31:24];
  assign seq_busy = r.busy;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_mode_gate: assert property (mode != MODE_NORMAL |=> r.state == ST_IDLE)
    else $error("sequencer active outside normal mode");
  a_slot_order: assert property ((r.state == ST_DELAY && r.slot_b && $past(r.state) != ST_DELAY)
    |-> ($past(r.state) == ST_COMPUTE && !$past(r.slot_b)) ||
        ($past(r.state) == ST_IDLE && $past(code_a) == 4'h0))
    else $error("slot B started out of order");
  a_skip_empty: assert property ((r.state == ST_DELAY && $past(r.state) == ST_IDLE)
    |-> (r.slot_b ? $past(code_b) : $past(code_a)) != 4'h0)
    else $error("unrouted slot was run");
  a_delay_len: assert property ((r.state != ST_DELAY && $past(r.state) == ST_DELAY
    && $past(mode) == MODE_NORMAL) |-> $past(r.chk_us) + 8'h01 == $past(cur_dly))
    else $error("LED delay length wrong");
  a_pulse_count: assert property ((r.state == ST_COMPUTE && $past(r.state) == ST_PULSE)
    |-> r.chk_led == $past(cur_cnt))
    else $error("pulse count wrong");
  a_compute_len: assert property ((r.state != ST_COMPUTE && $past(r.state) == ST_COMPUTE
    && $past(mode) == MODE_NORMAL) |-> $past(r.chk_us) + 8'h01 == $past(comp_us))
    else $error("compute time wrong");
  a_sleep_len: assert property ((r.state == ST_IDLE && $past(r.state) == ST_SLEEP
    && $past(mode) == MODE_NORMAL) |-> $past(r.chk_us) + 8'h01 == T_SLEEP_US)
    else $error("sleep shorter than minimum");
  a_led_slot: assert property (r.led_a |-> !r.slot_b && !r.led_b
    && r.route == dss_route(code_a))
    else $error("LED fired outside its slot");
  a_sync_wait: assert property ((r.state == ST_DELAY && $past(r.state) == ST_IDLE
    && sync_sel != SYNC_OFF) |-> $past(r.armed))
    else $error("sync start without synchronised edge");
endmodule // dss_sequencer

// File: shared/dss_pkg.sv
// constants and types shared by the dual slot sampling sequencer
package dss_pkg;
  // -----------------------------------------------------------------
  // register offsets and reset value
  // -----------------------------------------------------------------
  localparam logic [7:0] OFF_MODE = 8'h10;
  localparam logic [7:0] OFF_RATE = 8'h12;
  localparam logic [7:0] OFF_ROUTE = 8'h14;
  localparam logic [7:0] OFF_DLY_A = 8'h30;
  localparam logic [7:0] OFF_CNT_A = 8'h31;
  localparam logic [7:0] OFF_DLY_B = 8'h35;
  localparam logic [7:0] OFF_CNT_B = 8'h36;
  localparam logic [7:0] OFF_XCFG = 8'h38;
  localparam logic [7:0] OFF_CLK = 8'h4B;
  localparam logic [7:0] OFF_PIN = 8'h4F;
  localparam logic [15:0] REG_RESET = 16'h0000;
  // -----------------------------------------------------------------
  // field layout and codes
  // -----------------------------------------------------------------
  localparam int MODE_LSB = 0;
  localparam int ROUTE_A_LSB = 4;
  localparam int ROUTE_B_LSB = 8;
  localparam int LOW_LSB = 0;
  localparam int COUNT_LSB = 8;
  localparam int SYNC_LSB = 2;
  localparam int CLKSRC_LSB = 7;
  localparam int TRIM_LSB = 0;
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_PROGRAM = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] SYNC_OFF = 2'h0;
  localparam logic [1:0] SYNC_PIN0 = 2'h1;
  localparam logic [1:0] SYNC_PIN1 = 2'h2;
  localparam logic [1:0] CLKSRC_EXT = 2'h2;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_HZ = 50000000;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CLK_HZ = 32000;
  localparam int SAMPLE_DIV_BASE = CLK_HZ / SAMPLE_CLK_HZ;
  localparam int TRIM_CENTER = 32;
  localparam logic [7:0] T_COMPUTE_A_US = 8'h44;
  localparam logic [7:0] T_COMPUTE_B_US = 8'h14;
  localparam logic [7:0] T_SLEEP_US = 8'hDE;
  localparam logic [7:0] DLY_MIN_US = 8'h17;
  localparam logic [7:0] SPC_MIN_US = 8'h13;
  localparam logic [7:0] TIME_MAX_US = 8'h3F;

  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_PULSE, ST_COMPUTE, ST_SLEEP} dss_state_t;
endpackage

// File: src/dss_pin_sync.sv
// two-flop synchronisers and rising edge pulses for the two general pins
module dss_pin_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_level,
  output logic [1:0] pin_rise
);
  import dss_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] last;
    logic [1:0] rise;
  } dss_psync_t;

  dss_psync_t r;
  dss_psync_t n;

  always_comb
  begin
    n = r;
    n.meta = pin_in;
    n.sync = r.meta;
    n.last = r.sync;
    n.rise = r.sync & ~r.last;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign pin_level = r.sync;
  assign pin_rise = r.rise;
endmodule // dss_pin_sync

// File: src/dss_tick_gen.sv
// microsecond timebase and trimmed 32 kHz sample clock enables
module dss_tick_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] trim,
  input wire logic ext_sel,
  input wire logic ext_rise,
  output logic us_tick,
  output logic smp_tick
);
  import dss_pkg::*;

  typedef struct packed {
    logic [5:0] us_cnt;
    logic [10:0] smp_cnt;
    logic us_tick;
    logic smp_tick;
  } dss_tick_t;

  dss_tick_t r;
  dss_tick_t n;
  logic [10:0] smp_div;

  // trim moves the divider around its nominal value
  assign smp_div = 11'(SAMPLE_DIV_BASE - TRIM_CENTER) + {5'h00, trim};

  always_comb
  begin
    n = r;
    n.us_tick = 1'b0;
    n.smp_tick = 1'b0;
    if (r.us_cnt == 6'(US_CYCLES - 1))
    begin
      n.us_cnt = 6'h00;
      n.us_tick = 1'b1;
    end
    else
      n.us_cnt = r.us_cnt + 6'h01;
    if (ext_sel)
    begin
      n.smp_cnt = 11'h000;
      n.smp_tick = ext_rise;
    end
    else if (r.smp_cnt >= smp_div - 11'h001)
    begin
      n.smp_cnt = 11'h000;
      n.smp_tick = 1'b1;
    end
    else
      n.smp_cnt = r.smp_cnt + 11'h001;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign us_tick = r.us_tick;
  assign smp_tick = r.smp_tick;
endmodule // dss_tick_gen

// File: verif/dss_sync_source.sv
// sample-sync source and external 32 kHz reference on the general pins
module dss_sync_source (
  input wire logic clk,
  input wire logic [1:0] fire,
  input wire logic ext_en,
  output logic general_pin_zero,
  output logic general_pin_one
);
  timeunit 1ns;
  timeprecision 1ns;
  int hold [2] = '{0, 0};
  int ph = 0;
  initial
  begin
    general_pin_zero = 1'b0;
    general_pin_one = 1'b0;
  end
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
      hold[i] = fire[i] ? 100 : (hold[i] > 0 ? hold[i] - 1 : 0);
    ph = (ph + 1) % 1500;
    general_pin_zero <= hold[0] > 0;
    general_pin_one <= ext_en ? ph < 750 : hold[1] > 0;
  end
endmodule // dss_sync_source

// File: verif/testbench.sv
// self-checking bench for the dual slot sampling sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dss_pkg::*;
  typedef struct {byte k; string nm; logic [32:0] lo; logic [32:0] hi;} dss_note_t;
  logic clk, sys_rst, reg_wr, rd_mark, rd_due, ext_en, full_run;
  logic [7:0] reg_addr, ch1, ch2, ch3, ch4;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] fire;
  logic pin0, pin1, led1, led2, cap, smp, act_a, act_b, busy;
  logic [6:0] prv;
  logic [23:0] cnt, cnt_a, cnt_b;
  int n_mismatch, checks, since_start, since_pin, len_a, len_b, len_s;
  byte k;
  bit [31:0] rng = 33447;
  dss_note_t notes[$];
  logic [15:0] vals [10];
  logic [7:0] offs [10] = '{OFF_MODE, OFF_RATE, OFF_ROUTE, OFF_DLY_A, OFF_CNT_A,
    OFF_DLY_B, OFF_CNT_B, OFF_XCFG, OFF_CLK, OFF_PIN};
  // channel masks {ch4, ch3, ch2, ch1} per routing code
  logic [31:0] route_tab [8] = '{32'h0, 32'h0000030C, 32'h000030C0, 32'h0000000F,
    32'h80402010, 32'h08040201, 32'h0000300C, 32'h000000F0};

  dss_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .general_pin_zero(pin0), .general_pin_one(pin1), .emitter_output_first(led1),
    .emitter_output_second(led2), .capture_strobe(cap), .sample_start(smp),
    .slot_a_active(act_a), .slot_b_active(act_b), .route_channel_1(ch1),
    .route_channel_2(ch2), .route_channel_3(ch3), .route_channel_4(ch4), .seq_busy(busy));
  dss_sync_source u_src (.clk(clk), .fire(fire), .ext_en(ext_en),
    .general_pin_zero(pin0), .general_pin_one(pin1));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----
  // checking
  // ----
  task automatic print_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic note(input byte nk, input string nm, input logic [32:0] lo,
    input logic [32:0] hi);
    notes.push_back('{nk, nm, lo, hi});
  endtask

  task automatic take(input logic [32:0] seen);
    dss_note_t n;
    checks++;
    if (notes.size() == 0)
    begin
      n_mismatch++;
      $display("FAIL unexpected_result expected none seen %h", seen);
    end
    else
    begin
      n = notes.pop_front();
      if (((seen >= n.lo) && (seen <= n.hi)) !== 1'b1)
      begin
        n_mismatch++;
        $display("FAIL %s expected %h..%h seen %h", n.nm, n.lo, n.hi, seen);
      end
    end
  endtask

  always @(posedge clk)
  begin
    if (rd_due)
      take({17'h0, reg_rdata});
    rd_due = rd_mark;
    if (smp === 1'b1)
    begin
      k = (notes.size() > 0) ? notes[0].k : "R";
      take(k == "I" ? 33'(since_start) :
        k == "S" ? 33'(since_pin) : {ch4, ch3, ch2, ch1, act_a});
      since_start = 0;
      len_a = 0;
      len_b = 0;
      len_s = 0;
      cnt_a = 24'h0;
      cnt_b = 24'h0;
    end
    since_start++;
    since_pin++;
    if ((pin0 & ~prv[2]) | (pin1 & ~prv[3]))
      since_pin = 0;
    cnt = {7'h0, led1 & ~prv[0], 7'h0, led2 & ~prv[1], 7'h0, cap};
    if (act_a === 1'b1)
    begin
      len_a++;
      cnt_a += cnt;
    end
    if (act_b === 1'b1)
    begin
      len_b++;
      cnt_b += cnt;
    end
    if (busy === 1'b1 && act_a !== 1'b1 && act_b !== 1'b1)
      len_s++;
    if (full_run)
    begin
      if (prv[4] & ~act_a)
      begin
        take(33'(len_a));
        take({9'h0, cnt_a});
      end
      if (act_b & ~prv[5])
        take({ch4, ch3, ch2, ch1, act_a});
      if (prv[5] & ~act_b)
      begin
        take(33'(len_b));
        take({9'h0, cnt_b});
      end
      if (prv[6] & ~busy)
        take(33'(len_s));
    end
    prv = {busy, act_b, act_a, pin1, pin0, led2, led1};
  end

  // ----
  // stimulus
  // ----
  function automatic bit [31:0] xs(input bit [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    note("D", "reg_rdata", {17'h0, e}, {17'h0, e});
    @(negedge clk);
    reg_addr = a;
    rd_mark = 1'b1;
    @(negedge clk);
    rd_mark = 1'b0;
  endtask

  task automatic drain(input int lim);
    int i;
    i = 0;
    while (notes.size() > 0 && i < lim)
    begin
      @(negedge clk);
      i++;
    end
    if (notes.size() > 0)
    begin
      n_mismatch++;
      $display("FAIL %s expected result seen timeout", notes[0].nm);
      print_verdict();
    end
  endtask

  task automatic setup(input logic [15:0] route, input logic [15:0] pin,
    input logic [15:0] src, input logic [15:0] rate);
    wr(OFF_MODE, {14'h0, MODE_PROGRAM});
    wr(OFF_ROUTE, route);
    wr(OFF_PIN, pin);
    wr(OFF_CLK, src);
    wr(OFF_RATE, rate);
    wr(OFF_XCFG, 16'h4000);
    wr(OFF_MODE, {14'h0, MODE_NORMAL});
  endtask

  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rd_mark = 1'b0;
    rd_due = 1'b0;
    fire = 2'b00;
    ext_en = 1'b0;
    full_run = 1'b0;
    prv = 7'h0;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    foreach (offs[i]) rd(offs[i], REG_RESET);
    wr(OFF_MODE, {14'h0, MODE_PROGRAM});
    for (int i = 1; i < 10; i++)
    begin
      rng = xs(rng);
      vals[i] = rng[15:0];
      wr(offs[i], vals[i]);
    end
    for (int i = 1; i < 10; i++)
      rd(offs[i], vals[i]);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h0000);
    drain(50);
    // spacing 19 us meets the window floor
    wr(OFF_DLY_A, 16'h0017);
    wr(OFF_CNT_A, 16'h0213);
    wr(OFF_DLY_B, 16'h003F);
    wr(OFF_CNT_B, 16'h013F);
    for (int c = 0; c < 8; c++)
    begin
      note("R", "route", {route_tab[c], c != 0}, {route_tab[c], c != 0});
      setup(16'(c << 4), 16'h0000, 16'h0000, 16'h0001);
      drain(3000);
    end
    note("R", "route_a", {route_tab[4], 1'b1}, {route_tab[4], 1'b1});
    note("D", "slot_a_time", 33'(129 * 50 - 52), 33'(129 * 50 + 3));
    note("D", "slot_a_pulses", 33'h020002, 33'h020002);
    note("D", "route_b", {route_tab[5], 1'b0}, {route_tab[5], 1'b0});
    note("D", "slot_b_time", 33'(146 * 50 - 52), 33'(146 * 50 + 3));
    note("D", "slot_b_pulses", 33'h000101, 33'h000101);
    note("D", "sleep_time", 33'(222 * 50 - 2), 33'(222 * 50 + 52));
    setup(16'h0540, 16'h0000, 16'h0000, 16'h0001);
    full_run = 1'b1;
    drain(30000);
    full_run = 1'b0;
    for (int p = 0; p < 2; p++)
    begin
      setup(16'h0500, p ? 16'h0028 : 16'h0006, 16'h0000, 16'hFFFF);
      repeat (20) @(negedge clk);
      note("S", "sync_delay", 33'd1530, 33'd3070);
      fire = 2'(1 << p);
      @(negedge clk);
      fire = 2'b00;
      drain(4000);
    end
    // standby ignores sync edges
    wr(OFF_MODE, {14'h0, MODE_STANDBY});
    fire = 2'b10;
    @(negedge clk);
    fire = 2'b00;
    repeat (4000) @(negedge clk);
    ext_en = 1'b1;
    note("R", "first_start", 33'h0, 33'h0);
    note("I", "start_interval", 33'd11998, 33'd12002);
    setup(16'h0000, 16'h0020, 16'h0100, 16'h0008);
    drain(30000);
    print_verdict();
  end
endmodule // testbench
